// File: dac_gain_offset_datapath.sv
// top of the gain and offset correction datapath feeding the converter core
// assumes a host on the same clock driving the plain register port;
// format and power-up select come from pins and are synchronised here
`timescale 1ns/10ps
module dac_gain_offset_datapath
	import dac_corr_pkg::*;
#(
	parameter int unsigned BUSY_CNT = BUSY_CYCLES
) (
	input  wire logic                      clk_in,
	input  wire logic                      reset_n_in,
	input  wire logic                      input_format_select_in,
	input  wire logic                      midscale_select_in,
	input  wire logic [dac_corr_pkg::ADDR_W-1:0] addr_in,
	input  wire logic [dac_corr_pkg::DATA_W-1:0] wdata_in,
	input  wire logic                      wr_in,
	input  wire logic                      rd_in,
	output logic      [dac_corr_pkg::DATA_W-1:0] rdata_out,
	output logic                           busy_n_out,
	output logic      [17:0]               dac_value_out
);
	import dac_corr_pkg::*;

	logic [1:0]       pins_sync;
	logic             fmt_twos;
	logic             mid_sel;
	logic [1:0]       strap_cnt_r;
	logic             wr_code;
	logic             wr_gain;
	logic             wr_offset;
	logic             calc_done;
	logic [31:0]      rd_word;
	logic [17:0]      code_r;
	logic [17:0]      gain_r;
	logic [17:0]      offset_r;
	logic             change;
	logic [17:0]      calc_value;
	calc_state_t      state_r;
	calc_state_t      state_nxt;
	logic [CNT_W-1:0] count_r;
	logic [CNT_W-1:0] count_nxt;

	// synchronise the select pins
	pin_sync #(
		.WIDTH (2)
	) u_sync (
		.clk_in     (clk_in),
		.reset_n_in (reset_n_in),
		.async_in   ({midscale_select_in, input_format_select_in}),
		.sync_out   (pins_sync)
	);
	assign fmt_twos = pins_sync[0];
	assign mid_sel  = pins_sync[1];

	// arithmetic
	corr_arith u_arith (
		.code_in     (code_r),
		.gain_in     (gain_r),
		.offset_in   (offset_r),
		.twos_fmt_in (fmt_twos),
		.value_out   (calc_value)
	);

	// write strobe decoded per correction register
	always_comb begin
		wr_code   = 1'b0;
		wr_gain   = 1'b0;
		wr_offset = 1'b0;
		if (wr_in) begin
			if (addr_in == REG_DATA_IN) begin
				wr_code = 1'b1;
			end else if (addr_in == REG_GAIN) begin
				wr_gain = 1'b1;
			end else if (addr_in == REG_OFFSET) begin
				wr_offset = 1'b1;
			end
		end
	end

	// a write that alters a correction register; same value is ignored
	always_comb begin
		change = 1'b0;
		if (wr_code) begin
			change = (wdata_in[17:0] != code_r);
		end else if (wr_gain) begin
			change = (wdata_in[17:0] != gain_r);
		end else if (wr_offset) begin
			change = (wdata_in[17:0] != offset_r);
		end
	end

	// input code register
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			code_r <= CODE_ZERO;
		end else if (wr_code) begin
			code_r <= wdata_in[17:0];
		end
	end

	// gain register, unsigned in every format
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			gain_r <= GAIN_RESET;
		end else if (wr_gain) begin
			gain_r <= wdata_in[17:0];
		end
	end

	// offset register, signed in every format
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			offset_r <= OFFSET_RESET;
		end else if (wr_offset) begin
			offset_r <= wdata_in[17:0];
		end
	end

	// calc state machine with restart on change
	always_comb begin
		state_nxt = state_r;
		count_nxt = count_r;
		case (state_r)
			ST_IDLE: begin
				if (change) begin
					state_nxt = ST_CALC;
					count_nxt = CNT_W'(BUSY_CNT - 1);
				end
			end
			ST_CALC: begin
				if (change) begin
					count_nxt = CNT_W'(BUSY_CNT - 1);
				end else if (count_r == '0) begin
					state_nxt = ST_IDLE;
				end else begin
					count_nxt = count_r - 1'b1;
				end
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state_r <= ST_IDLE;
			count_r <= '0;
		end else begin
			state_r <= state_nxt;
			count_r <= count_nxt;
		end
	end

	// busy low while computing
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			busy_n_out <= 1'b1;
		end else begin
			busy_n_out <= (state_nxt == ST_IDLE);
		end
	end

	// last cycle of a computation
	assign calc_done = (state_r == ST_CALC) && (state_nxt == ST_IDLE);

	// strap window: the select pin needs two edges through the synchroniser
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			strap_cnt_r <= 2'h0;
		end else if (strap_cnt_r != STRAP_LAST) begin
			strap_cnt_r <= strap_cnt_r + 2'h1;
		end
	end

	// converter value: power-up state, then corrected value when done
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			dac_value_out <= CODE_ZERO;
		end else if (strap_cnt_r != STRAP_LAST) begin
			dac_value_out <= mid_sel ? CODE_MID : CODE_ZERO;
		end else if (calc_done) begin
			dac_value_out <= calc_value;
		end
	end

	// read word selection; unmapped addresses read zero
	always_comb begin
		rd_word = '0;
		if (addr_in == REG_DATA_IN) begin
			rd_word = {14'h0000, code_r};
		end else if (addr_in == REG_GAIN) begin
			rd_word = {14'h0000, gain_r};
		end else if (addr_in == REG_OFFSET) begin
			rd_word = {14'h0000, offset_r};
		end else if (addr_in == REG_STATUS) begin
			rd_word = {6'h00, dac_value_out, 6'h00, fmt_twos, busy_n_out};
		end
	end

	// read port, data one cycle after strobe and zero otherwise
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			rdata_out <= '0;
		end else if (rd_in) begin
			rdata_out <= rd_word;
		end else begin
			rdata_out <= '0;
		end
	end
endmodule

// File: dac_corr_pkg.sv
// package for the gain and offset correction datapath
// holds widths, codes, register offsets and timing counts shared by all modules except the pin synchroniser and the host model
package dac_corr_pkg;
	localparam int unsigned CODE_W       = 18;
	localparam int unsigned ACC_W        = 21;
	localparam int unsigned ADDR_W       = 4;
	localparam int unsigned DATA_W       = 32;
	// register offsets on the plain register port
	localparam logic [3:0]  REG_DATA_IN  = 4'h0;
	localparam logic [3:0]  REG_GAIN     = 4'h4;
	localparam logic [3:0]  REG_OFFSET   = 4'h8;
	localparam logic [3:0]  REG_STATUS   = 4'hC;
	// field positions in the status register
	localparam int unsigned ST_BUSY_BIT  = 0;
	localparam int unsigned ST_FMT_BIT   = 1;
	localparam int unsigned ST_VAL_LSB   = 8;
	// code values
	localparam logic [17:0] CODE_ZERO    = 18'h00000;
	localparam logic [17:0] CODE_MID     = 18'h20000;
	localparam logic [17:0] CODE_FULL    = 18'h3FFFF;
	localparam logic [17:0] GAIN_RESET   = 18'h3FFFF;
	localparam logic [17:0] OFFSET_RESET = 18'h00000;
	// computation time
	localparam int unsigned CLK_MHZ      = 50;
	localparam int unsigned BUSY_TIME_PS = 1900000;
	localparam int unsigned BUSY_CYCLES  = (BUSY_TIME_PS * CLK_MHZ) / 1000000;
	localparam int unsigned CNT_W        = 8;
	// last count of the power-up strap window, after the pin synchroniser settles
	localparam logic [1:0]  STRAP_LAST   = 2'h3;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CALC = 2'b01
	} calc_state_t;
endpackage

// File: pin_sync.sv
// two flip-flop synchroniser for pin inputs
// assumes an asynchronous active-low reset in the destination clock domain
`timescale 1ns/10ps
module pin_sync #(
	parameter int unsigned WIDTH = 1
) (
	input  wire logic             clk_in,
	input  wire logic             reset_n_in,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1_r;

	// first stage feeds only the second stage
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			stage1_r <= '0;
			sync_out <= '0;
		end else begin
			stage1_r <= async_in;
			sync_out <= stage1_r;
		end
	end
endmodule

// File: corr_arith.sv
// combinational gain, offset and clipping arithmetic
// assumes registered inputs from the same clock; result is registered by the caller
`timescale 1ns/10ps
module corr_arith
	import dac_corr_pkg::*;
(
	input  wire logic [17:0] code_in,
	input  wire logic [17:0] gain_in,
	input  wire logic [17:0] offset_in,
	input  wire logic        twos_fmt_in,
	output logic      [17:0] value_out
);
	logic signed [20:0] scaled;
	logic signed [20:0] acc;
	logic signed [18:0] signed_code;

	// signed view of the input code in two's complement mode
	always_comb begin
		signed_code = twos_fmt_in ? {code_in[17], code_in} : {1'b0, code_in};
	end

	// full precision product, keep upper bits, add offset, clip
	always_comb begin
		logic signed [38:0] prod_s;
		prod_s = 39'(signed_code) * $signed({1'b0, 19'(gain_in) + 19'h00001});
		scaled = 21'(prod_s >>> CODE_W);
		if (twos_fmt_in) begin
			scaled = scaled + $signed({3'b000, CODE_MID});
		end
		acc = scaled + 21'($signed(offset_in));
		if (acc < 0) begin
			value_out = CODE_ZERO;
		end else if (acc > $signed({3'b000, CODE_FULL})) begin
			value_out = CODE_FULL;
		end else begin
			value_out = acc[17:0];
		end
	end
endmodule

// File: dac_corr_checker.sv
// checker for busy timing, power-up value and status reads of the datapath
// sees only the top ports; busy_held assumes BUSY_CNT of at least 4
`timescale 1ns/10ps
module dac_corr_checker
	import dac_corr_pkg::*;
#(
	parameter int unsigned BUSY_CNT = 95
) (
	input wire logic              clk_in,
	input wire logic              reset_n_in,
	input wire logic              input_format_select_in,
	input wire logic              midscale_select_in,
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic [DATA_W-1:0] wdata_in,
	input wire logic              wr_in,
	input wire logic              rd_in,
	input wire logic [DATA_W-1:0] rdata_out,
	input wire logic              busy_n_out,
	input wire logic [17:0]       dac_value_out
);
	logic [7:0] cnt_r;
	logic [1:0] age_r;
	logic [17:0] sh_code_r;
	logic [17:0] sh_gain_r;
	logic [17:0] sh_off_r;
	// write that alters one of the three data registers
	wire logic wd = wr_in && ((addr_in == REG_DATA_IN && wdata_in[17:0] != sh_code_r) ||
		(addr_in == REG_GAIN && wdata_in[17:0] != sh_gain_r) ||
		(addr_in == REG_OFFSET && wdata_in[17:0] != sh_off_r));
	// shadow copies of the written registers
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			sh_code_r <= CODE_ZERO;
			sh_gain_r <= GAIN_RESET;
			sh_off_r  <= OFFSET_RESET;
		end else if (wr_in) begin
			if (addr_in == REG_DATA_IN) begin
				sh_code_r <= wdata_in[17:0];
			end else if (addr_in == REG_GAIN) begin
				sh_gain_r <= wdata_in[17:0];
			end else if (addr_in == REG_OFFSET) begin
				sh_off_r <= wdata_in[17:0];
			end
		end
	end
	// cycles since last data write, and edges since reset
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			cnt_r <= 8'hFF;
			age_r <= 2'h0;
		end else begin
			cnt_r <= wd ? 8'h01 : cnt_r + {7'h0, cnt_r != 8'hFF};
			age_r <= age_r + {1'b0, age_r != 2'h3};
		end
	end
	default clocking @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);
	a_fall_write: assert property ($fell(busy_n_out) |-> $past(wr_in))
		else $error("busy fell without a write");
	a_busy_len: assert property ($rose(busy_n_out) |-> cnt_r == BUSY_CNT + 1)
		else $error("busy length wrong");
	a_busy_held: assert property ($fell(busy_n_out) |-> !busy_n_out [*4])
		else $error("busy released early");
	a_dac_done: assert property (age_r == 2'h3 && $past(age_r) == 2'h3 && $changed(dac_value_out)
		|-> $rose(busy_n_out))
		else $error("value changed outside completion");
	a_reset_val: assert property (age_r == 2'h3 && $past(age_r) == 2'h2 |->
		dac_value_out == (midscale_select_in ? CODE_MID : CODE_ZERO))
		else $error("power-up value wrong");
	a_stat_val: assert property ($past(rd_in) && $past(addr_in) == REG_STATUS |->
		rdata_out[25:8] == $past(dac_value_out) && rdata_out[0] == $past(busy_n_out))
		else $error("status value wrong");
	a_stat_fmt: assert property ($past(rd_in) && $past(addr_in) == REG_STATUS |->
		rdata_out[1] == $past(input_format_select_in, 3))
		else $error("status format wrong");
	a_unmapped_zero: assert property ($past(rd_in) && $past(addr_in[1:0]) != 2'h0 |-> rdata_out == '0)
		else $error("unmapped read not zero");
endmodule
bind dac_gain_offset_datapath dac_corr_checker #(.BUSY_CNT(BUSY_CNT)) chk_i (.*);

// File: reg_host.sv
// register port master model: one-cycle strobes launched after rising edges
// assumes the datapath never stalls and answers reads one cycle later
`timescale 1ns/10ps
module reg_host (
	input  wire logic        clk_in,
	input  wire logic [31:0] rdata_in,
	output logic      [3:0]  addr_out = 4'h0,
	output logic      [31:0] wdata_out = 32'h0,
	output logic             wr_out = 1'b0,
	output logic             rd_out = 1'b0
);
	// single write cycle
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_in);
		addr_out <= a;
		wdata_out <= d;
		wr_out <= 1'b1;
		@(posedge clk_in);
		wr_out <= 1'b0;
	endtask
	// single read cycle, data taken at the edge that closes the cycle after it
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk_in);
		addr_out <= a;
		rd_out <= 1'b1;
		@(posedge clk_in);
		rd_out <= 1'b0;
		@(posedge clk_in);
		d = rdata_in;
	endtask
endmodule

// File: dac_gain_offset_datapath_bench.sv
// bench for the correction datapath: resets, register sequences, readback
// assumes reg_host as master and a short computation count of 4
`timescale 1ns/10ps
module dac_gain_offset_datapath_bench;
	import dac_corr_pkg::*;
	logic        clk_in = 1'b0;
	logic        reset_n_in = 1'b0;
	logic        fmt = 1'b0;
	logic        mid = 1'b0;
	logic [3:0]  addr;
	logic [31:0] wdata, rdata, rv;
	logic        wr, rd, busy_n;
	logic [17:0] dac, e;
	int          err_count = 0;
	int          cmp_count = 0;
	int          cyc = 0;
	logic [9:0]  tf = 10'h3E0;
	logic [17:0] tc[10] = '{18'h3FFFF, 18'h20000, 18'h30000, 18'h3FFFF, 18'h10000,
		18'h20000, 18'h00000, 18'h1FFFF, 18'h30000, 18'h10000};
	logic [17:0] tg[10] = '{18'h3FFFF, 18'h2FFFF, 18'h0FFFF, 18'h3FFFF, 18'h00000,
		18'h3FFFF, 18'h3FFFF, 18'h3FFFF, 18'h2FFFF, 18'h0FFFF};
	logic [17:0] to[10] = '{18'h00000, 18'h10000, 18'h30000, 18'h10000, 18'h00005,
		18'h00000, 18'h00000, 18'h00000, 18'h08000, 18'h38000};
	always #10 clk_in = ~clk_in;
	dac_gain_offset_datapath #(.BUSY_CNT(4)) DUT (.clk_in(clk_in), .reset_n_in(reset_n_in),
		.input_format_select_in(fmt), .midscale_select_in(mid), .addr_in(addr),
		.wdata_in(wdata), .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .busy_n_out(busy_n),
		.dac_value_out(dac));
	reg_host host (.clk_in(clk_in), .rdata_in(rdata), .addr_out(addr), .wdata_out(wdata),
		.wr_out(wr), .rd_out(rd));
	// expected corrected code: truncated product, midscale term, offset, clip
	function automatic logic [17:0] ref_val(input logic f, input logic [17:0] c, g, o);
		logic signed [40:0] a;
		a = f ? $signed(c) : $signed({1'b0, c});
		a = (a * $signed({2'b00, g} + 20'h00001)) >>> 18;
		a = a + (f ? 41'sh20000 : 41'sh0) + $signed(o);
		return (a < 0) ? CODE_ZERO : (a > 41'sh3FFFF) ? CODE_FULL : a[17:0];
	endfunction
	task automatic chk(input string n, input logic [31:0] x, g);
		cmp_count++;
		if (g !== x) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", n, x, g);
		end
	endtask
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// reset with the power-up select pin held at m
	task automatic rst(input logic m);
		mid <= m;
		reset_n_in <= 1'b0;
		repeat (8) @(posedge clk_in);
		reset_n_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		#1 chk("reset value", {14'h0, m ? CODE_MID : CODE_ZERO}, {14'h0, dac});
	endtask
	// bounded wait for the end of a computation
	task automatic wait_done();
		for (int n = 0; n < 20 && busy_n !== 1'b1; n++) @(posedge clk_in);
		#1 chk("done", 32'h1, {31'h0, busy_n});
	endtask
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			err_count++;
			complete_run();
		end
	end
	initial begin
		rst(1'b1);
		rst(1'b0);
		host.rd(REG_GAIN, rv);
		chk("gain reset", {14'h0, GAIN_RESET}, rv);
		host.rd(REG_OFFSET, rv);
		chk("offset reset", {14'h0, OFFSET_RESET}, rv);
		for (int i = 0; i < 10; i++) begin
			@(posedge clk_in);
			fmt <= tf[i];
			host.wr(REG_GAIN, {14'h0, tg[i]});
			host.wr(REG_OFFSET, {14'h0, to[i]});
			host.wr(REG_DATA_IN, {14'h0, tc[i]});
			#1 chk("busy", 32'h0, {31'h0, busy_n});
			wait_done();
			e = ref_val(tf[i], tc[i], tg[i], to[i]);
			chk("value", {14'h0, e}, {14'h0, dac});
		end
		host.rd(REG_STATUS, rv);
		chk("status", {6'h0, e, 6'h0, 2'b11}, rv);
		host.rd(4'h2, rv);
		chk("unmapped", 32'h0, rv);
		host.wr(REG_DATA_IN, {14'h0, tc[9]});
		#1 chk("same write", 32'h1, {31'h0, busy_n});
		complete_run();
	end
endmodule
